// ---- sysctl_consts.vh ----
// Constants for the system control block: register map, field positions, reset values.
// Assumes a byte-wide register port with one-cycle read latency.
`ifndef SYSCTL_CONSTS_VH
`define SYSCTL_CONSTS_VH
// ****************************************
// Register offsets
// ****************************************
`define ADDR_PIN_IRQ 4'h0
`define ADDR_PMC1 4'h1
`define ADDR_PMC3 4'h2
`define ADDR_RST_SRC 4'h3
`define ADDR_CGC1 4'h4
`define ADDR_CGC2 4'h5
`define ADDR_W 4
// ****************************************
// Pin interrupt register fields
// ****************************************
`define PIN_PULL_DIS 6
`define PIN_POL 5
`define PIN_FEN 4
`define PIN_FLAG 3
`define PIN_CLR 2
`define PIN_IE 1
`define PIN_MODE 0
// ****************************************
// Power management 1 fields
// ****************************************
`define PM1_FLAG 7
`define PM1_CLR 6
`define PM1_IE 5
`define PM1_RE 4
`define PM1_SE 3
`define PM1_DE 2
// ****************************************
// Power management 3 fields
// ****************************************
`define PM3_FLAG 7
`define PM3_CLR 6
`define PM3_IE 5
// ****************************************
// Reset source fields
// ****************************************
`define RS_POR 7
`define RS_LVD 1
// ****************************************
// Reset values
// ****************************************
`define RST_PIN_IRQ 8'h00
`define RST_PMC1 8'h1c
`define RST_PMC3 8'h00
`define RST_CGC 8'hff
`define ZERO8 8'h00
`endif

// ---- sync2.v ----
// Two-stage synchroniser for one level.
// Assumes the input may change at any time relative to CLK.
`timescale 1ns/10ps
module sync2 (
  input wire clk,
  input wire nrst,
  input wire din,
  output wire dout
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
    end
  end
  assign dout = s2_ff;
endmodule // sync2

// ---- sticky_flag.v ----
// Sticky flag: set wins over clear, clear may be held off.
// Assumes synchronous set and clear pulses.
`timescale 1ns/10ps
module sticky_flag (
  input wire clk,
  input wire nrst,
  input wire set,
  input wire clr,
  output wire flag
);
  reg flag_ff;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= 1'b0;
    end else if (set) begin
      flag_ff <= 1'b1;
    end else if (clr) begin
      flag_ff <= 1'b0;
    end
  end
  assign flag = flag_ff;
endmodule // sticky_flag

// ---- sysctl_top.v ----
// System control: low-voltage detect/warning, peripheral clock gating, pin interrupt.
// Assumes all inputs synchronous to CLK except IRQ_PIN_I, which is synchronised here.
`timescale 1ns/10ps
`include "sysctl_consts.vh"
// Behaviour
// - Low-voltage detection runs only while its enable bit is set.
// - Stop modes switch detection off unless stop enable bit is set.
// - Both enables set: deep stop request becomes shallow stop.
// - Power-on reset sets power-on and low-voltage reset status bits.
// - Reset enable set: low voltage resets and holds reset; status bit set.
// - Detect, interrupt enable set, reset enable clear: flag and request.
// - Writing 1 to detect clear bit clears the detect flag.
// - Warning request whenever warning flag and warning enable both set.
// - Writing 1 to warning clear bit clears the warning flag.
// - After any reset all peripheral clocks are enabled.
// - Clock gating writes take effect right after the write.
// - Gated-off peripheral ignores register writes and does not operate.
// - Any stop mode stops all gated peripheral clocks.
// - Bit 6 disconnects pull device; 0 keeps it active when enabled.
// - Bit 5 selects polarity; high polarity makes pull a pull-down.
// - Bit 4 enables the pin interrupt function.
// - Bit 3 reads the event flag, set on qualifying events.
// - Bit 2 write 1 clears flag; reads zero.
// - Level mode: clear blocked while pin at asserted level.
// - Bit 1 enables interrupt request while flag is set.
// - Bit 0 selects edge only or edge and level detection.
module sysctl_top #(
  parameter NPERIPH = 16
) (
  input wire CLK,
  input wire NRST,
  input wire POR_EVENT,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire LV_DETECT,
  input wire LV_WARNING,
  input wire STOP_REQ,
  input wire STOP_DEEP_REQ,
  output wire STOP_DEEP,
  output wire STOP_SHALLOW,
  output wire LVD_ACTIVE,
  output wire LVD_RESET_REQ,
  output wire LVD_IRQ,
  output wire LVW_IRQ,
  output wire [NPERIPH-1:0] PERIPH_CLK_EN,
  input wire [NPERIPH-1:0] PERIPH_WR_REQ,
  output wire [NPERIPH-1:0] PERIPH_WR_EN,
  input wire IRQ_PIN_I,
  output wire PIN_PULL_EN,
  output wire PIN_PULL_DOWN,
  output wire PIN_IRQ
);
  // ****************************************
  // Register state
  // ****************************************
  reg pin_pull_disable_ff;
  reg pin_polarity_select_ff;
  reg pin_function_enable_ff;
  reg pin_int_enable_ff;
  reg pin_detect_mode_ff;
  reg lowvolt_int_enable_ff;
  reg lowvolt_reset_enable_ff;
  reg lowvolt_stop_enable_ff;
  reg lowvolt_detect_enable_ff;
  reg lowvolt_warning_int_enable_ff;
  reg rs_por_ff;
  reg rs_lvd_ff;
  reg [15:0] cgc_ff;
  reg pin_prev_ff;
  wire pin_sync;
  wire pin_event_flag;
  wire lowvolt_detect_flag;
  wire lowvolt_warning_flag;
  wire wr_pin = WR && (ADDR == `ADDR_PIN_IRQ);
  wire wr_pm1 = WR && (ADDR == `ADDR_PMC1);
  wire wr_pm3 = WR && (ADDR == `ADDR_PMC3);
  wire wr_cg1 = WR && (ADDR == `ADDR_CGC1);
  wire wr_cg2 = WR && (ADDR == `ADDR_CGC2);
  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_pull_disable_ff <= 1'b0;
      pin_polarity_select_ff <= 1'b0;
      pin_function_enable_ff <= 1'b0;
      pin_int_enable_ff <= 1'b0;
      pin_detect_mode_ff <= 1'b0;
      lowvolt_int_enable_ff <= 1'b0;
      lowvolt_reset_enable_ff <= 1'b1;
      lowvolt_stop_enable_ff <= 1'b1;
      lowvolt_detect_enable_ff <= 1'b1;
      lowvolt_warning_int_enable_ff <= 1'b0;
      cgc_ff <= {`RST_CGC, `RST_CGC};
    end else begin
      if (wr_pin) begin
        pin_pull_disable_ff <= WDATA[`PIN_PULL_DIS];
        pin_polarity_select_ff <= WDATA[`PIN_POL];
        pin_function_enable_ff <= WDATA[`PIN_FEN];
        pin_int_enable_ff <= WDATA[`PIN_IE];
        pin_detect_mode_ff <= WDATA[`PIN_MODE];
      end
      if (wr_pm1) begin
        lowvolt_int_enable_ff <= WDATA[`PM1_IE];
        lowvolt_reset_enable_ff <= WDATA[`PM1_RE];
        lowvolt_stop_enable_ff <= WDATA[`PM1_SE];
        lowvolt_detect_enable_ff <= WDATA[`PM1_DE];
      end
      if (wr_pm3) begin
        lowvolt_warning_int_enable_ff <= WDATA[`PM3_IE];
      end
      if (wr_cg1) begin
        cgc_ff[7:0] <= WDATA;
      end
      if (wr_cg2) begin
        cgc_ff[15:8] <= WDATA;
      end
    end
  end
  // ****************************************
  // Reset source status
  // ****************************************
  // POR_EVENT is a synchronous pulse marking a power-on reset release
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rs_por_ff <= 1'b0;
      rs_lvd_ff <= 1'b0;
    end else if (POR_EVENT) begin
      rs_por_ff <= 1'b1;
      rs_lvd_ff <= 1'b1;
    end else if (LVD_RESET_REQ) begin
      rs_por_ff <= 1'b0;
      rs_lvd_ff <= 1'b1;
    end
  end
  // ****************************************
  // Low-voltage detect and warning
  // ****************************************
  wire in_stop = STOP_REQ;
  assign LVD_ACTIVE = lowvolt_detect_enable_ff &&
                      (!in_stop || lowvolt_stop_enable_ff);
  wire lv_seen = LVD_ACTIVE && LV_DETECT;
  assign LVD_RESET_REQ = lv_seen && lowvolt_reset_enable_ff;
  wire lvd_set = lv_seen && !lowvolt_reset_enable_ff;
  wire lvd_redirect = lowvolt_detect_enable_ff && lowvolt_stop_enable_ff;
  assign STOP_DEEP = STOP_REQ && STOP_DEEP_REQ && !lvd_redirect;
  assign STOP_SHALLOW = STOP_REQ && !STOP_DEEP;
  sticky_flag u_lvd_flag (
    .clk(CLK),
    .nrst(NRST),
    .set(lvd_set),
    .clr(wr_pm1 && WDATA[`PM1_CLR]),
    .flag(lowvolt_detect_flag)
  );
  assign LVD_IRQ = lowvolt_detect_flag && lowvolt_int_enable_ff &&
                   !lowvolt_reset_enable_ff;
  sticky_flag u_lvw_flag (
    .clk(CLK),
    .nrst(NRST),
    .set(LV_WARNING && LVD_ACTIVE),
    .clr(wr_pm3 && WDATA[`PM3_CLR]),
    .flag(lowvolt_warning_flag)
  );
  assign LVW_IRQ = lowvolt_warning_flag && lowvolt_warning_int_enable_ff;
  // ****************************************
  // Peripheral clock gating
  // ****************************************
  assign PERIPH_CLK_EN = in_stop ? {NPERIPH{1'b0}} : cgc_ff[NPERIPH-1:0];
  assign PERIPH_WR_EN = PERIPH_WR_REQ & PERIPH_CLK_EN;
  // ****************************************
  // Pin interrupt
  // ****************************************
  sync2 u_pin_sync (
    .clk(CLK),
    .nrst(NRST),
    .din(IRQ_PIN_I),
    .dout(pin_sync)
  );
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pin_sync;
    end
  end
  wire pin_asserted = pin_polarity_select_ff ? pin_sync : !pin_sync;
  wire prev_asserted = pin_polarity_select_ff ? pin_prev_ff : !pin_prev_ff;
  wire pin_edge = pin_asserted && !prev_asserted;
  wire pin_level = pin_detect_mode_ff && pin_asserted;
  wire pin_set = pin_function_enable_ff && (pin_edge || pin_level);
  sticky_flag u_pin_flag (
    .clk(CLK),
    .nrst(NRST),
    .set(pin_set),
    .clr(wr_pin && WDATA[`PIN_CLR]),
    .flag(pin_event_flag)
  );
  assign PIN_IRQ = pin_event_flag && pin_int_enable_ff;
  assign PIN_PULL_EN = pin_function_enable_ff && !pin_pull_disable_ff;
  assign PIN_PULL_DOWN = PIN_PULL_EN && pin_polarity_select_ff;
  // ****************************************
  // Read data
  // ****************************************
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = `ZERO8;
    case (ADDR)
      `ADDR_PIN_IRQ: begin
        nxt_rdata[`PIN_PULL_DIS] = pin_pull_disable_ff;
        nxt_rdata[`PIN_POL] = pin_polarity_select_ff;
        nxt_rdata[`PIN_FEN] = pin_function_enable_ff;
        nxt_rdata[`PIN_FLAG] = pin_event_flag;
        nxt_rdata[`PIN_IE] = pin_int_enable_ff;
        nxt_rdata[`PIN_MODE] = pin_detect_mode_ff;
      end
      `ADDR_PMC1: begin
        nxt_rdata[`PM1_FLAG] = lowvolt_detect_flag;
        nxt_rdata[`PM1_IE] = lowvolt_int_enable_ff;
        nxt_rdata[`PM1_RE] = lowvolt_reset_enable_ff;
        nxt_rdata[`PM1_SE] = lowvolt_stop_enable_ff;
        nxt_rdata[`PM1_DE] = lowvolt_detect_enable_ff;
      end
      `ADDR_PMC3: begin
        nxt_rdata[`PM3_FLAG] = lowvolt_warning_flag;
        nxt_rdata[`PM3_IE] = lowvolt_warning_int_enable_ff;
      end
      `ADDR_RST_SRC: begin
        nxt_rdata[`RS_POR] = rs_por_ff;
        nxt_rdata[`RS_LVD] = rs_lvd_ff;
      end
      `ADDR_CGC1: nxt_rdata = cgc_ff[7:0];
      `ADDR_CGC2: nxt_rdata = cgc_ff[15:8];
      default: nxt_rdata = `ZERO8;
    endcase
  end
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= `ZERO8;
    end else if (RD) begin
      RDATA <= nxt_rdata;
    end else begin
      RDATA <= `ZERO8;
    end
  end
endmodule // sysctl_top

// ---- sysctl_chk.sv ----
// Port checker for the system control block.
// Assumes binding into sysctl_top; shadows control bits from bus writes.
`timescale 1ns/10ps
`include "sysctl_consts.vh"
module sysctl_chk #(
  parameter NPERIPH = 16
) (
  input wire CLK,
  input wire NRST,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire STOP_REQ,
  input wire STOP_DEEP,
  input wire LVD_ACTIVE,
  input wire LVD_RESET_REQ,
  input wire LV_DETECT,
  input wire LVD_IRQ,
  input wire LVW_IRQ,
  input wire [NPERIPH-1:0] PERIPH_CLK_EN,
  input wire [NPERIPH-1:0] PERIPH_WR_REQ,
  input wire [NPERIPH-1:0] PERIPH_WR_EN,
  input wire IRQ_PIN_I,
  input wire PIN_PULL_EN,
  input wire PIN_PULL_DOWN,
  input wire PIN_IRQ
);
  // ****
  // Shadow registers
  // ****
  reg [7:0] pin_ff;
  reg [7:0] pm1_ff;
  reg [7:0] pm3_ff;
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_ff <= `RST_PIN_IRQ;
      pm1_ff <= `RST_PMC1;
      pm3_ff <= `RST_PMC3;
    end else if (WR) begin
      if (ADDR == `ADDR_PIN_IRQ) pin_ff <= WDATA;
      if (ADDR == `ADDR_PMC1) pm1_ff <= WDATA;
      if (ADDR == `ADDR_PMC3) pm3_ff <= WDATA;
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_edge;
    pin_ff[4] && pin_ff[1] && (pin_ff[5] ? $rose(IRQ_PIN_I) : $fell(IRQ_PIN_I));
  endsequence
  a_edge_flag: assert property (s_edge |-> ##[2:4] PIN_IRQ)
    else $error("pin edge not flagged");
  a_wr_gate: assert property (PERIPH_WR_EN == (PERIPH_WR_REQ & PERIPH_CLK_EN))
    else $error("write gate wrong");
  a_stop_gate: assert property (STOP_REQ |-> PERIPH_CLK_EN == '0)
    else $error("clock runs in stop");
  a_clk_write: assert property ($past(WR) && $past(ADDR) == `ADDR_CGC1 && !STOP_REQ
    |-> PERIPH_CLK_EN[7:0] == $past(WDATA))
    else $error("gating write late");
  a_deep_lvd: assert property (STOP_DEEP |-> !LVD_ACTIVE)
    else $error("deep stop with detect on");
  a_lvd_enable: assert property (LVD_ACTIVE |-> pm1_ff[2] && !(STOP_REQ && !pm1_ff[3]))
    else $error("detect on wrongly");
  a_lvd_hold: assert property (LVD_RESET_REQ |-> LV_DETECT && pm1_ff[4])
    else $error("reset hold wrong");
  a_lvd_irq: assert property (LVD_IRQ |-> pm1_ff[5])
    else $error("detect irq unmasked");
  a_lvw_irq: assert property (LVW_IRQ |-> pm3_ff[5])
    else $error("warning irq unmasked");
  a_pull_en: assert property (PIN_PULL_EN == (pin_ff[4] && !pin_ff[6]))
    else $error("pull enable wrong");
  a_pull_dir: assert property (PIN_PULL_EN |-> PIN_PULL_DOWN == pin_ff[5])
    else $error("pull direction wrong");
  a_pin_irq: assert property (PIN_IRQ |-> pin_ff[1])
    else $error("pin irq unmasked");
endmodule // sysctl_chk
bind sysctl_top sysctl_chk #(.NPERIPH(NPERIPH)) sysctl_chk_inst (.CLK, .NRST, .ADDR, .WDATA,
  .WR, .STOP_REQ, .STOP_DEEP, .LVD_ACTIVE, .LVD_RESET_REQ, .LV_DETECT, .LVD_IRQ, .LVW_IRQ,
  .PERIPH_CLK_EN, .PERIPH_WR_REQ, .PERIPH_WR_EN, .IRQ_PIN_I, .PIN_PULL_EN, .PIN_PULL_DOWN,
  .PIN_IRQ);

// ---- pin_src.sv ----
// External device on the interrupt pin.
// Assumes a released pin settles at the pull level, and toggles every clock when the pull is off.
`timescale 1ns/10ps
module pin_src (
  input wire clk,
  input wire drive,
  input wire level,
  input wire pull_en,
  input wire pull_down,
  output reg pin
);
  initial pin = 1'b1;
  always @(posedge clk) begin
    if (drive) pin <= level;
    else if (pull_en) pin <= !pull_down;
    else pin <= !pin;
  end
endmodule // pin_src

// ---- sysctl_top_test.sv ----
// Testbench for sysctl_top.
// Assumes sysctl_chk is bound and pin_src drives the pin.
`timescale 1ns/10ps
`include "sysctl_consts.vh"
`define CHK(g,e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module sysctl_top_test;
  reg CLK, NRST, POR_EVENT, WR, RD, LV_DETECT, LV_WARNING, STOP_REQ, STOP_DEEP_REQ;
  reg drv_en, drv_lvl;
  reg [3:0] ADDR;
  reg [7:0] WDATA;
  reg [15:0] PERIPH_WR_REQ;
  wire [7:0] RDATA;
  wire [15:0] PERIPH_CLK_EN, PERIPH_WR_EN;
  wire STOP_DEEP, STOP_SHALLOW, LVD_ACTIVE, LVD_RESET_REQ, LVD_IRQ, LVW_IRQ;
  wire IRQ_PIN_I, PIN_PULL_EN, PIN_PULL_DOWN, PIN_IRQ;
  integer failures = 0, cmp_count = 0, cycles = 0;
  sysctl_top #(.NPERIPH(16)) sysctl_top_inst (.CLK, .NRST, .POR_EVENT, .ADDR, .WDATA, .WR,
    .RD, .RDATA, .LV_DETECT, .LV_WARNING, .STOP_REQ, .STOP_DEEP_REQ, .STOP_DEEP,
    .STOP_SHALLOW, .LVD_ACTIVE, .LVD_RESET_REQ, .LVD_IRQ, .LVW_IRQ, .PERIPH_CLK_EN,
    .PERIPH_WR_REQ, .PERIPH_WR_EN, .IRQ_PIN_I, .PIN_PULL_EN, .PIN_PULL_DOWN, .PIN_IRQ);
  pin_src pin_src_inst (.clk(CLK), .drive(drv_en), .level(drv_lvl), .pull_en(PIN_PULL_EN),
    .pull_down(PIN_PULL_DOWN), .pin(IRQ_PIN_I));
  // ****
  // Bus tasks
  // ****
  task wr(input [3:0] a, input [7:0] d);
    @(posedge CLK) begin ADDR <= a; WDATA <= d; WR <= 1; end
    @(posedge CLK) WR <= 0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge CLK) begin ADDR <= a; RD <= 1; end
    @(posedge CLK) RD <= 0;
    @(negedge CLK) `CHK(RDATA, e)
  endtask
  task nw(input integer n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask
  task conclude;
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    CLK = 0;
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    {NRST, POR_EVENT, WR, RD, LV_DETECT, LV_WARNING, STOP_REQ, STOP_DEEP_REQ} = 0;
    {drv_en, drv_lvl} = 2'b11;
    ADDR = 0;
    WDATA = 0;
    PERIPH_WR_REQ = 16'hffff;
    repeat (12) @(posedge CLK);
    NRST <= 1;
    @(posedge CLK) POR_EVENT <= 1;
    @(posedge CLK) POR_EVENT <= 0;
    nw(0); `CHK(PERIPH_CLK_EN, 16'hffff)
    rd(`ADDR_PIN_IRQ, 8'h00); rd(`ADDR_PMC1, `RST_PMC1); rd(`ADDR_PMC3, 8'h00);
    rd(`ADDR_CGC2, 8'hff); rd(4'hf, 8'h00); rd(`ADDR_RST_SRC, 8'h82);
    wr(`ADDR_CGC1, 8'h00); nw(0); `CHK(PERIPH_WR_EN, 16'hff00)
    wr(`ADDR_CGC2, 8'h0f); nw(0); `CHK(PERIPH_CLK_EN, 16'h0f00)
    @(posedge CLK) {STOP_REQ, STOP_DEEP_REQ} <= 2'b11;
    nw(1); `CHK(PERIPH_CLK_EN, 16'h0000)
    `CHK({LVD_ACTIVE, STOP_SHALLOW, STOP_DEEP}, 3'b110)
    wr(`ADDR_PMC1, 8'h14); nw(0); `CHK({LVD_ACTIVE, STOP_DEEP}, 2'b01)
    @(posedge CLK) {STOP_REQ, STOP_DEEP_REQ} <= 2'b00;
    nw(1); `CHK(LVD_ACTIVE, 1'b1)
    @(posedge CLK) LV_DETECT <= 1;
    nw(1); `CHK(LVD_RESET_REQ, 1'b1)
    rd(`ADDR_RST_SRC, 8'h02);
    @(posedge CLK) LV_DETECT <= 0;
    wr(`ADDR_PMC1, 8'h00); nw(0); `CHK({LVD_ACTIVE, LVD_RESET_REQ}, 2'b00)
    wr(`ADDR_PMC1, 8'h24);
    @(posedge CLK) begin LV_DETECT <= 1; LV_WARNING <= 1; end
    @(posedge CLK) begin LV_DETECT <= 0; LV_WARNING <= 0; end
    rd(`ADDR_PMC1, 8'ha4); `CHK(LVD_IRQ, 1'b1)
    wr(`ADDR_PMC1, 8'h64); rd(`ADDR_PMC1, 8'h24);
    wr(`ADDR_PMC3, 8'h20); nw(0); `CHK(LVW_IRQ, 1'b1)
    wr(`ADDR_PMC3, 8'h60); rd(`ADDR_PMC3, 8'h20);
    wr(`ADDR_PIN_IRQ, 8'h12); nw(0); `CHK({PIN_PULL_EN, PIN_PULL_DOWN}, 2'b10)
    @(posedge CLK) drv_lvl <= 0;
    rd(`ADDR_PIN_IRQ, 8'h12); nw(4); `CHK(PIN_IRQ, 1'b1)
    rd(`ADDR_PIN_IRQ, 8'h1a); wr(`ADDR_PIN_IRQ, 8'h16); rd(`ADDR_PIN_IRQ, 8'h12);
    wr(`ADDR_PIN_IRQ, 8'h13); nw(2); wr(`ADDR_PIN_IRQ, 8'h17);
    rd(`ADDR_PIN_IRQ, 8'h1b);
    @(posedge CLK) drv_lvl <= 1;
    nw(4); wr(`ADDR_PIN_IRQ, 8'h17); rd(`ADDR_PIN_IRQ, 8'h13);
    wr(`ADDR_PIN_IRQ, 8'h32); nw(0); `CHK(PIN_PULL_DOWN, 1'b1)
    @(posedge CLK) drv_en <= 0;
    nw(4); `CHK(IRQ_PIN_I, 1'b0)
    rd(`ADDR_PIN_IRQ, 8'h32); @(posedge CLK) drv_en <= 1;
    nw(5); rd(`ADDR_PIN_IRQ, 8'h3a);
    wr(`ADDR_PIN_IRQ, 8'h74); nw(0); `CHK(PIN_PULL_EN, 1'b0)
    @(posedge CLK) drv_lvl <= 0;
    nw(5); rd(`ADDR_PIN_IRQ, 8'h70); wr(`ADDR_PIN_IRQ, 8'h50);
    @(posedge CLK) drv_lvl <= 1;
    nw(2); @(posedge CLK) drv_lvl <= 0;
    nw(5); rd(`ADDR_PIN_IRQ, 8'h58); `CHK(PIN_IRQ, 1'b0)
    wr(`ADDR_PIN_IRQ, 8'h06); @(posedge CLK) drv_lvl <= 1;
    nw(2); @(posedge CLK) drv_lvl <= 0;
    nw(5); rd(`ADDR_PIN_IRQ, 8'h02); `CHK(PIN_IRQ, 1'b0)
    conclude;
  end
endmodule // sysctl_top_test
